// file: rtl/rsq_consts.svh
// Offsets, field positions, reset values and timing counts of the ring slave sequencer.
// Contract
// - Firmware sets init-done after loading; device then leaves INITIAL for setup phase A.
// - IN or OUT slaves leave INITIAL for setup phase A without init-done.
// - Frames received in INITIAL are discarded with no reply or store; only frame-received strobe pulses.
// - Phase A accepts only setup-A, forwards it with node info, enters phase B.
// - Phase B forwards setup-B, runs on cyclic frame, returns to A on setup-A.
// - RUNNING exchanges cyclic frames and returns to phase A on setup-A.
// - Writing 1 to soft reset forces the sequencer back to INITIAL.
// - Own block position in receive memory stays fixed after phase B.
// - Both strobes are active-low pulses of 1.28 us, falling edge significant.
// - Sync strobe fires only in RUNNING after a complete cyclic frame.
// - Frame-received strobe pulses on every complete frame, any state or type.
// - In RUNNING a timeout also pulses frame-received strobe unless masked.
// - IN or OUT slave samples or updates its pins at the sync strobe.
// - The slave never transmits unless a received frame triggers it.
// - Reply carries transmit bank committed before the triggering frame arrived.
// - A reply-preventing error acts as no frame: no store, no strobes.
// - Generic timeout interval is programmed; IN and OUT use fixed 20.9 ms.
// - BCD node address above 31 or lower digit Ah to Fh reads 31.
// - Generic host bus is 16 bits with width select low, 8 bits high.
// - Status reports state one-hot: bit3 INITIAL, bit2 A, bit1 B, bit0 RUNNING.
// - Timeout value zero disables detection, else value times 81.92 us.
`ifndef RSQ_CONSTS_SVH
`define RSQ_CONSTS_SVH

`define RSQ_CLK_MHZ        20
`define RSQ_STROBE_NS      1280
`define RSQ_STROBE_CYC     ((`RSQ_STROBE_NS * `RSQ_CLK_MHZ + 999) / 1000)
`define RSQ_TO_UNIT_NS     81920
`define RSQ_TO_UNIT_CYC    ((`RSQ_TO_UNIT_NS * `RSQ_CLK_MHZ) / 1000)
`define RSQ_FIXED_TO_US    20900
`define RSQ_FIXED_TO_CYC   (`RSQ_FIXED_TO_US * `RSQ_CLK_MHZ)

`define RSQ_OFF_SOFT_RESET 12'h500
`define RSQ_OFF_NODE_ADDR  12'h504
`define RSQ_OFF_TIMEOUT    12'h50c
`define RSQ_OFF_INIT_DONE  12'h510
`define RSQ_OFF_STRB_MASK  12'h514
`define RSQ_OFF_SYNC_MASK  12'h51c
`define RSQ_OFF_TX_SWITCH  12'h530
`define RSQ_OFF_STATE      12'h544

`define RSQ_TIMEOUT_RST    8'hff
`define RSQ_STATE_TO_BIT   4
`define RSQ_BCD_MAX        5'h1f
`define RSQ_BCD_DIGIT_MAX  4'h9

`endif

// file: rtl/rsq_pkg.sv
// Types shared by the ring slave sequencer.
package rsq_pkg;

  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_CFGA = 2'b01,
    ST_CFGB = 2'b10,
    ST_RUN  = 2'b11
  } rsq_state_e;

  typedef enum logic [1:0] {
    FT_NONE  = 2'b00,
    FT_SETA  = 2'b01,
    FT_SETB  = 2'b10,
    FT_CYCLE = 2'b11
  } rsq_frame_e;

  typedef enum logic [1:0] {
    MD_NONE    = 2'b00,
    MD_GENERIC = 2'b01,
    MD_IN      = 2'b10,
    MD_OUT     = 2'b11
  } rsq_mode_e;

endpackage : rsq_pkg

// file: rtl/rsq_ring_slave_sequencer.sv
// Start-up sequencer, reply trigger, strobes and timeout of a ring slave node.
//
// Local design decisions: the register offsets and the APB register port.
`include "rsq_consts.svh"

module rsq_ring_slave_sequencer
  import rsq_pkg::*;
#(
  parameter int unsigned FIXED_TIMEOUT_CYC = `RSQ_FIXED_TO_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  slave_mode,
  input  wire logic        host_bus_width_select,
  input  wire logic [7:0]  node_address_pins,
  input  wire logic        rx_done,
  input  wire logic [1:0]  rx_type,
  input  wire logic        rx_fatal,
  input  wire logic [4:0]  rx_block_pos,
  output logic             tx_start,
  output logic             tx_append_info,
  output logic             tx_bank,
  output logic             rx_store,
  output logic [4:0]       block_pos,
  output logic [4:0]       node_address,
  output logic             host_bus_16bit,
  output logic             io_sample,
  output logic             frame_received_strobe_n,
  output logic             cycle_sync_strobe_n
);

  localparam logic [4:0]  STROBE_CYC = 5'(`RSQ_STROBE_CYC);
  localparam logic [10:0] TO_UNIT    = 11'(`RSQ_TO_UNIT_CYC);

  function automatic logic [4:0] dec5(input logic [4:0] v);
    dec5 = (v == 5'h00) ? 5'h00 : v - 5'h01;
  endfunction : dec5

  function automatic logic [4:0] bcd_addr(input logic [7:0] p);
    logic [7:0] v;
    v = 8'(p[7:4]) * 8'h0a + 8'(p[3:0]);
    if (p[3:0] > `RSQ_BCD_DIGIT_MAX || v > 8'(`RSQ_BCD_MAX)) begin
      bcd_addr = `RSQ_BCD_MAX;
    end else begin
      bcd_addr = v[4:0];
    end
  endfunction : bcd_addr

  // Register bus group.
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic        init_done_r, init_done_nxt;
  logic [4:0]  macid_r, macid_nxt;
  logic [7:0]  timeout_r, timeout_nxt;
  logic        strb_mask_r, strb_mask_nxt;
  logic        sync_mask_r, sync_mask_nxt;
  logic        cpu_bank_r, cpu_bank_nxt;
  logic        soft_rst;

  // Sequencer group.
  rsq_state_e  state_r, state_nxt;
  logic        tx_start_r, tx_start_nxt;
  logic        append_r, append_nxt;
  logic        tx_bank_r, tx_bank_nxt;
  logic        store_r, store_nxt;
  logic [4:0]  blk_pos_r, blk_pos_nxt;
  logic [4:0]  node_r, node_nxt;
  logic        bus16_r, bus16_nxt;
  logic        sync_go;

  // Timer group.
  logic [4:0]  fr_cnt_r, fr_cnt_nxt;
  logic [4:0]  sy_cnt_r, sy_cnt_nxt;
  logic        fr_n_r, fr_n_nxt;
  logic        sy_n_r, sy_n_nxt;
  logic        io_smp_r, io_smp_nxt;
  logic [19:0] to_cnt_r, to_cnt_nxt;
  logic        to_flag_r, to_flag_nxt;
  logic        to_hit;

  logic io_mode;
  logic rx_ok;
  logic setup_ph;
  logic acc_ph;
  logic mapped;
  logic [31:0] rd_mux;

  assign io_mode  = (slave_mode == MD_IN) || (slave_mode == MD_OUT);
  assign rx_ok    = rx_done && !rx_fatal;
  assign setup_ph = psel && !penable;
  assign acc_ph   = psel && penable && pready_r;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `RSQ_OFF_SOFT_RESET: rd_mux = 32'h0000_0000;
      `RSQ_OFF_NODE_ADDR:  rd_mux = {27'h0, macid_r};
      `RSQ_OFF_TIMEOUT:    rd_mux = {24'h0, timeout_r};
      `RSQ_OFF_INIT_DONE:  rd_mux = {31'h0, init_done_r};
      `RSQ_OFF_STRB_MASK:  rd_mux = {31'h0, strb_mask_r};
      `RSQ_OFF_SYNC_MASK:  rd_mux = {31'h0, sync_mask_r};
      `RSQ_OFF_TX_SWITCH:  rd_mux = 32'h0000_0000;
      `RSQ_OFF_STATE: begin
        rd_mux[3] = (state_r == ST_INIT);
        rd_mux[2] = (state_r == ST_CFGA);
        rd_mux[1] = (state_r == ST_CFGB);
        rd_mux[0] = (state_r == ST_RUN);
        rd_mux[`RSQ_STATE_TO_BIT] = to_flag_r;
      end
      default: mapped = 1'b0;
    endcase
  end

  // Registers are written at the access edge; soft reset also restores defaults.
  always_comb begin
    prdata_nxt    = prdata_r;
    pready_nxt    = setup_ph;
    pslverr_nxt   = setup_ph && !mapped;
    init_done_nxt = init_done_r;
    macid_nxt     = macid_r;
    timeout_nxt   = timeout_r;
    strb_mask_nxt = strb_mask_r;
    sync_mask_nxt = sync_mask_r;
    cpu_bank_nxt  = cpu_bank_r;
    soft_rst      = 1'b0;
    if (setup_ph && !pwrite) begin
      prdata_nxt = rd_mux;
    end
    if (acc_ph && pwrite && !pslverr_r) begin
      case (paddr)
        `RSQ_OFF_SOFT_RESET: soft_rst = pwdata[0];
        `RSQ_OFF_NODE_ADDR:  macid_nxt = pwdata[4:0];
        `RSQ_OFF_TIMEOUT:    timeout_nxt = pwdata[7:0];
        `RSQ_OFF_INIT_DONE:  init_done_nxt = pwdata[0];
        `RSQ_OFF_STRB_MASK:  strb_mask_nxt = pwdata[0];
        `RSQ_OFF_SYNC_MASK:  sync_mask_nxt = pwdata[0];
        `RSQ_OFF_TX_SWITCH:  cpu_bank_nxt = cpu_bank_r ^ pwdata[0];
        default: cpu_bank_nxt = cpu_bank_r;
      endcase
    end
    if (soft_rst) begin
      init_done_nxt = 1'b0;
      macid_nxt     = 5'h00;
      timeout_nxt   = `RSQ_TIMEOUT_RST;
      strb_mask_nxt = 1'b0;
      sync_mask_nxt = 1'b0;
      cpu_bank_nxt  = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r    <= 32'h0000_0000;
      pready_r    <= 1'b0;
      pslverr_r   <= 1'b0;
      init_done_r <= 1'b0;
      macid_r     <= 5'h00;
      timeout_r   <= `RSQ_TIMEOUT_RST;
      strb_mask_r <= 1'b0;
      sync_mask_r <= 1'b0;
      cpu_bank_r  <= 1'b0;
    end else begin
      prdata_r    <= prdata_nxt;
      pready_r    <= pready_nxt;
      pslverr_r   <= pslverr_nxt;
      init_done_r <= init_done_nxt;
      macid_r     <= macid_nxt;
      timeout_r   <= timeout_nxt;
      strb_mask_r <= strb_mask_nxt;
      sync_mask_r <= sync_mask_nxt;
      cpu_bank_r  <= cpu_bank_nxt;
    end
  end

  // A reply is only ever started by an accepted frame; the bank it carries is the
  // one software committed before that frame arrived.
  always_comb begin
    state_nxt    = state_r;
    tx_start_nxt = 1'b0;
    append_nxt   = 1'b0;
    store_nxt    = 1'b0;
    sync_go      = 1'b0;
    blk_pos_nxt  = blk_pos_r;
    tx_bank_nxt  = tx_bank_r;
    case (state_r)
      ST_INIT: begin
        if (init_done_r || io_mode) begin
          state_nxt = ST_CFGA;
        end
      end
      ST_CFGA: begin
        if (rx_ok && rx_type == FT_SETA) begin
          tx_start_nxt = 1'b1;
          append_nxt   = 1'b1;
          blk_pos_nxt  = rx_block_pos;
          state_nxt    = ST_CFGB;
        end
      end
      ST_CFGB: begin
        if (rx_ok && rx_type == FT_SETB) begin
          tx_start_nxt = 1'b1;
          append_nxt   = 1'b1;
          blk_pos_nxt  = rx_block_pos;
        end else if (rx_ok && rx_type == FT_SETA) begin
          state_nxt = ST_CFGA;
        end else if (rx_ok && rx_type == FT_CYCLE) begin
          state_nxt    = ST_RUN;
          tx_start_nxt = 1'b1;
          store_nxt    = 1'b1;
          sync_go      = 1'b1;
        end
      end
      ST_RUN: begin
        if (rx_ok && rx_type == FT_CYCLE) begin
          tx_start_nxt = 1'b1;
          store_nxt    = 1'b1;
          sync_go      = 1'b1;
        end else if (rx_ok && rx_type == FT_SETA) begin
          state_nxt = ST_CFGA;
        end
      end
      default: state_nxt = ST_INIT;
    endcase
    if (tx_start_nxt) begin
      tx_bank_nxt = !cpu_bank_r;
    end
    if (soft_rst) begin
      state_nxt    = ST_INIT;
      tx_start_nxt = 1'b0;
      append_nxt   = 1'b0;
      store_nxt    = 1'b0;
      sync_go      = 1'b0;
    end
    if (io_mode && host_bus_width_select) begin
      node_nxt = bcd_addr(node_address_pins);
    end else if (io_mode) begin
      node_nxt = node_address_pins[4:0];
    end else begin
      node_nxt = macid_r;
    end
    bus16_nxt = !host_bus_width_select;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= ST_INIT;
      tx_start_r <= 1'b0;
      append_r   <= 1'b0;
      tx_bank_r  <= 1'b0;
      store_r    <= 1'b0;
      blk_pos_r  <= 5'h00;
      node_r     <= 5'h00;
      bus16_r    <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      tx_start_r <= tx_start_nxt;
      append_r   <= append_nxt;
      tx_bank_r  <= tx_bank_nxt;
      store_r    <= store_nxt;
      blk_pos_r  <= blk_pos_nxt;
      node_r     <= node_nxt;
      bus16_r    <= bus16_nxt;
    end
  end

  // Strobe widths and the receive timeout run on the system clock.
  always_comb begin
    logic        to_en;
    logic [19:0] to_lim;
    to_en  = 1'b0;
    to_lim = 20'(FIXED_TIMEOUT_CYC);
    if (!io_mode) begin
      to_lim = 20'(timeout_r) * 20'(TO_UNIT);
    end
    to_en  = (state_r == ST_RUN) && (io_mode || timeout_r != 8'h00);
    to_hit = to_en && !rx_ok && (to_cnt_r == to_lim - 20'h1);
    if (!to_en || rx_ok || to_hit) begin
      to_cnt_nxt = 20'h0;
    end else begin
      to_cnt_nxt = to_cnt_r + 20'h1;
    end
    to_flag_nxt = to_hit ? 1'b1 : (rx_ok ? 1'b0 : to_flag_r);
    if (rx_ok || (to_hit && !strb_mask_r)) begin
      fr_cnt_nxt = STROBE_CYC;
    end else begin
      fr_cnt_nxt = dec5(fr_cnt_r);
    end
    if (sync_go && !sync_mask_r) begin
      sy_cnt_nxt = STROBE_CYC;
    end else begin
      sy_cnt_nxt = dec5(sy_cnt_r);
    end
    fr_n_nxt   = (fr_cnt_nxt == 5'h00);
    sy_n_nxt   = (sy_cnt_nxt == 5'h00);
    io_smp_nxt = sync_go && io_mode;
    if (soft_rst) begin
      to_cnt_nxt  = 20'h0;
      to_flag_nxt = 1'b0;
      fr_cnt_nxt  = 5'h00;
      sy_cnt_nxt  = 5'h00;
      fr_n_nxt    = 1'b1;
      sy_n_nxt    = 1'b1;
      io_smp_nxt  = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fr_cnt_r  <= 5'h00;
      sy_cnt_r  <= 5'h00;
      fr_n_r    <= 1'b1;
      sy_n_r    <= 1'b1;
      io_smp_r  <= 1'b0;
      to_cnt_r  <= 20'h0;
      to_flag_r <= 1'b0;
    end else begin
      fr_cnt_r  <= fr_cnt_nxt;
      sy_cnt_r  <= sy_cnt_nxt;
      fr_n_r    <= fr_n_nxt;
      sy_n_r    <= sy_n_nxt;
      io_smp_r  <= io_smp_nxt;
      to_cnt_r  <= to_cnt_nxt;
      to_flag_r <= to_flag_nxt;
    end
  end

  assign prdata                  = prdata_r;
  assign pready                  = pready_r;
  assign pslverr                 = pslverr_r;
  assign tx_start                = tx_start_r;
  assign tx_append_info          = append_r;
  assign tx_bank                 = tx_bank_r;
  assign rx_store                = store_r;
  assign block_pos               = blk_pos_r;
  assign node_address            = node_r;
  assign host_bus_16bit          = bus16_r;
  assign io_sample               = io_smp_r;
  assign frame_received_strobe_n = fr_n_r;
  assign cycle_sync_strobe_n     = sy_n_r;

  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [5:0] fr_low_len;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fr_low_len <= 6'h00;
    end else begin
      fr_low_len <= (fr_cnt_nxt == STROBE_CYC) ? 6'h01 : (fr_n_r ? 6'h00 : fr_low_len + 6'h01);
    end
  end

  sequence seq_seta_in_a;
    state_r == ST_CFGA && rx_ok && rx_type == FT_SETA && !soft_rst;
  endsequence
  sequence seq_cycle_in_b;
    state_r == ST_CFGB && rx_ok && rx_type == FT_CYCLE && !soft_rst;
  endsequence

  a_init_discard: assert property (state_r == ST_INIT |=> !tx_start_r && !store_r)
    else $error("frame acted on in initial state");
  a_seta_reply: assert property (seq_seta_in_a
    |=> tx_start_r && append_r && state_r == ST_CFGB) else $error("setup-A not forwarded");
  a_cycle_enter_run: assert property (seq_cycle_in_b |=> state_r == ST_RUN && store_r)
    else $error("cyclic frame did not start running");
  a_run_back_to_a: assert property (state_r == ST_RUN && rx_ok && rx_type == FT_SETA
    && !soft_rst |=> state_r == ST_CFGA) else $error("no return to setup A");
  a_soft_reset: assert property (soft_rst |=> state_r == ST_INIT && fr_n_r && sy_n_r)
    else $error("soft reset missed");
  a_block_fixed: assert property (state_r == ST_RUN && $past(state_r) == ST_RUN
    |-> $stable(blk_pos_r)) else $error("block position moved");
  a_strobe_width: assert property ($rose(fr_n_r) && $past(fr_cnt_r) == 5'h01
    |-> $past(fr_low_len) == 6'(STROBE_CYC)) else $error("strobe width wrong");
  a_sync_in_run: assert property ($fell(cycle_sync_strobe_n) |-> state_r == ST_RUN)
    else $error("sync outside running");
  a_frame_strobe: assert property (rx_ok && !soft_rst
    |=> !fr_n_r ##1 (!fr_n_r || $past(soft_rst))) else $error("frame strobe missing");
  a_timeout_strobe: assert property (to_hit && !strb_mask_r && !soft_rst |=> !fr_n_r)
    else $error("timeout strobe missing");
  a_io_sample: assert property (io_smp_r && !$past(sync_mask_r)
    |-> !cycle_sync_strobe_n && sy_cnt_r == STROBE_CYC) else $error("pin sample not on sync");
  a_reply_cause: assert property (tx_start_r |-> $past(rx_ok))
    else $error("unsolicited transmit");
  a_tx_bank: assert property (tx_start_r |-> tx_bank_r == !$past(cpu_bank_r))
    else $error("reply bank not committed one");
  a_fatal_quiet: assert property (rx_done && rx_fatal && !to_hit
    |=> !tx_start_r && !store_r) else $error("fatal frame acted on");

endmodule : rsq_ring_slave_sequencer

// file: verification/rsq_ring_master_model.sv
// Ring master model that delivers received-frame events to the slave sequencer.
module rsq_ring_master_model
  import rsq_pkg::*;
(
  input  wire logic       pclk,
  output logic            rx_done,
  output logic [1:0]      rx_type,
  output logic            rx_fatal,
  output logic [4:0]      rx_block_pos
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    rx_done = 1'b0;
    rx_type = 2'b00;
    rx_fatal = 1'b0;
    rx_block_pos = 5'h00;
  end

  // The qualifiers only mean something with rx_done, so they are scrambled afterwards.
  task automatic send(input rsq_frame_e t, input logic f, input logic [4:0] p);
    rx_done <= 1'b1;
    rx_type <= t;
    rx_fatal <= f;
    rx_block_pos <= p;
    @(posedge pclk);
    rx_done <= 1'b0;
    rx_type <= ~t;
    rx_fatal <= ~f;
    rx_block_pos <= ~p;
    @(posedge pclk);
  endtask : send

endmodule : rsq_ring_master_model

// file: verification/rsq_ring_slave_sequencer_test.sv
// Self-checking bench of the ring slave start-up sequence, replies, strobes and timeout.
`include "rsq_consts.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("ERROR %0t: got %0h expected %0h", $time, (got), (exp)); end end

module rsq_ring_slave_sequencer_test
  import rsq_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  slave_mode, rx_type;
  logic        host_bus_width_select, rx_done, rx_fatal, tx_start, tx_append_info;
  logic        tx_bank, rx_store, host_bus_16bit, io_sample, done_q, fs_q, sy_q;
  logic        frame_received_strobe_n, cycle_sync_strobe_n;
  logic [7:0]  node_address_pins;
  logic [4:0]  rx_block_pos, block_pos, node_address;
  int          mismatches, total_checks, cyc, n_tx, n_ap, n_st, n_fs, n_sy, n_io;
  int          lw_s, lw_f, w_sy, w_fs;

  rsq_ring_slave_sequencer #(.FIXED_TIMEOUT_CYC(200)) rsq_ring_slave_sequencer_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .slave_mode, .host_bus_width_select, .node_address_pins, .rx_done,
    .rx_type, .rx_fatal, .rx_block_pos, .tx_start, .tx_append_info, .tx_bank,
    .rx_store, .block_pos, .node_address, .host_bus_16bit, .io_sample,
    .frame_received_strobe_n, .cycle_sync_strobe_n
  );

  rsq_ring_master_model rsq_ring_master_model_i (
    .pclk, .rx_done, .rx_type, .rx_fatal, .rx_block_pos
  );

  always #25 pclk = ~pclk;

  // Counts one-cycle pulses and strobe falling edges so scenarios can judge deltas.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      test_done();
    end
    if (tx_start === 1'b1) `CHK(done_q, 1'b1)
    done_q <= rx_done;
    fs_q <= frame_received_strobe_n;
    sy_q <= cycle_sync_strobe_n;
    n_tx += int'(tx_start === 1'b1);
    n_ap += int'(tx_append_info === 1'b1);
    n_st += int'(rx_store === 1'b1);
    n_io += int'(io_sample === 1'b1);
    n_fs += int'(fs_q === 1'b1 && frame_received_strobe_n === 1'b0);
    n_sy += int'(sy_q === 1'b1 && cycle_sync_strobe_n === 1'b0);
    if (cycle_sync_strobe_n === 1'b0) lw_s++;
    else if (lw_s != 0) begin
      w_sy = lw_s;
      lw_s = 0;
    end
    if (frame_received_strobe_n === 1'b0) lw_f++;
    else if (lw_f != 0) begin
      w_fs = lw_f;
      lw_f = 0;
    end
  end

  task automatic test_done();
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  task automatic do_reset(input logic [1:0] m, input logic w, input logic [7:0] a);
    presetn <= 1'b0;
    slave_mode <= m;
    host_bus_width_select <= w;
    node_address_pins <= a;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : do_reset

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic st(input logic [4:0] e);
    apb(1'b0, `RSQ_OFF_STATE, 32'h0);
    `CHK(rd[4:0], e)
  endtask : st

  // Expected deltas are nibbles: reply, append, store, frame strobe, sync strobe.
  task automatic frame(input rsq_frame_e t, input logic f, input logic [4:0] p,
                       input logic [19:0] e, input logic ign = 1'b0);
    int          b[5];
    logic [19:0] g;
    b = '{n_tx, n_ap, n_st, n_fs, n_sy};
    rsq_ring_master_model_i.send(t, f, p);
    repeat (30) @(posedge pclk);
    g = {4'(n_tx - b[0]), 4'(n_ap - b[1]), 4'(n_st - b[2]), 4'(n_fs - b[3]), 4'(n_sy - b[4])};
    if (ign) g[3:0] = e[3:0];
    `CHK(g, e)
  endtask : frame

  task automatic t_startup();
    @(posedge pclk);
    `CHK(host_bus_16bit, 1'b1)
    host_bus_width_select <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK(host_bus_16bit, 1'b0)
    st(5'h08);
    frame(FT_SETA, 1'b0, 5'h03, 20'h00010);
    st(5'h08);
    apb(1'b1, `RSQ_OFF_INIT_DONE, 32'h1);
    st(5'h04);
    frame(FT_SETB, 1'b0, 5'h03, 20'h00010);
    frame(FT_CYCLE, 1'b0, 5'h03, 20'h00010);
    frame(FT_SETA, 1'b0, 5'h03, 20'h11010);
    st(5'h02);
    frame(FT_SETA, 1'b0, 5'h03, 20'h00010);
    st(5'h04);
    frame(FT_SETA, 1'b0, 5'h03, 20'h11010);
    frame(FT_SETB, 1'b0, 5'h03, 20'h11010);
    frame(FT_CYCLE, 1'b0, 5'h03, 20'h10110, 1'b1);
    st(5'h01);
  endtask : t_startup

  task automatic t_running();
    frame(FT_CYCLE, 1'b0, 5'h09, 20'h10111);
    `CHK(w_sy, `RSQ_STROBE_CYC)
    `CHK(w_fs, `RSQ_STROBE_CYC)
    `CHK(block_pos, 5'h03)
    `CHK(tx_bank, 1'b1)
    apb(1'b1, `RSQ_OFF_TX_SWITCH, 32'h1);
    `CHK(tx_bank, 1'b1)
    frame(FT_CYCLE, 1'b0, 5'h09, 20'h10111);
    `CHK(tx_bank, 1'b0)
    frame(FT_CYCLE, 1'b1, 5'h09, 20'h00000);
    apb(1'b1, `RSQ_OFF_SYNC_MASK, 32'h1);
    frame(FT_CYCLE, 1'b0, 5'h09, 20'h10110);
    apb(1'b1, `RSQ_OFF_SYNC_MASK, 32'h0);
    frame(FT_SETB, 1'b0, 5'h09, 20'h00010);
    st(5'h01);
  endtask : t_running

  task automatic t_timeout();
    int b;
    apb(1'b1, `RSQ_OFF_TIMEOUT, 32'h1);
    frame(FT_CYCLE, 1'b0, 5'h09, 20'h10111);
    b = n_fs;
    repeat (`RSQ_TO_UNIT_CYC - 60) @(posedge pclk);
    `CHK(n_fs - b, 0)
    repeat (100) @(posedge pclk);
    `CHK(n_fs - b, 1)
    st(5'h11);
    apb(1'b1, `RSQ_OFF_STRB_MASK, 32'h1);
    frame(FT_CYCLE, 1'b0, 5'h09, 20'h10111);
    b = n_fs;
    repeat (`RSQ_TO_UNIT_CYC + 100) @(posedge pclk);
    `CHK(n_fs - b, 0)
  endtask : t_timeout

  task automatic t_soft_reset();
    frame(FT_SETA, 1'b0, 5'h09, 20'h00010);
    st(5'h04);
    apb(1'b1, `RSQ_OFF_NODE_ADDR, 32'h15);
    @(posedge pclk);
    `CHK(node_address, 5'h15)
    apb(1'b1, `RSQ_OFF_SOFT_RESET, 32'h1);
    st(5'h08);
    `CHK(node_address, 5'h00)
    frame(FT_SETA, 1'b0, 5'h09, 20'h00010);
    apb(1'b0, `RSQ_OFF_TIMEOUT, 32'h0);
    `CHK(rd, 32'h000000ff)
    apb(1'b1, 12'h600, 32'h1);
    `CHK(er, 1'b1)
    st(5'h08);
  endtask : t_soft_reset

  task automatic t_io_slave();
    int b;
    do_reset(MD_IN, 1'b1, 8'h3a);
    st(5'h04);
    `CHK(node_address, 5'h1f)
    node_address_pins <= 8'h25;
    repeat (2) @(posedge pclk);
    `CHK(node_address, 5'h19)
    node_address_pins <= 8'h40;
    repeat (2) @(posedge pclk);
    `CHK(node_address, 5'h1f)
    node_address_pins <= 8'hd0;
    repeat (2) @(posedge pclk);
    `CHK(node_address, 5'h1f)
    host_bus_width_select <= 1'b0;
    node_address_pins <= 8'h25;
    repeat (2) @(posedge pclk);
    `CHK(node_address, 5'h05)
    frame(FT_SETA, 1'b0, 5'h00, 20'h11010);
    frame(FT_SETB, 1'b0, 5'h00, 20'h11010);
    frame(FT_CYCLE, 1'b0, 5'h00, 20'h10110, 1'b1);
    b = n_io;
    frame(FT_CYCLE, 1'b0, 5'h00, 20'h10111);
    `CHK(n_io - b, 1)
    b = n_fs;
    repeat (210) @(posedge pclk);
    `CHK(n_fs - b, 1)
  endtask : t_io_slave

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    slave_mode = MD_GENERIC;
    host_bus_width_select = 1'b0;
    node_address_pins = 8'h00;
    do_reset(MD_GENERIC, 1'b0, 8'h00);
    t_startup();
    t_running();
    t_timeout();
    t_soft_reset();
    t_io_slave();
    test_done();
  end

endmodule : rsq_ring_slave_sequencer_test
